/* File: pedc_far_side.sv */
`timescale 1ns/10ps
`default_nettype none
module pedc_far_side (
    input  wire logic        clk_in,
    input  wire logic [7:0]  pin_out_in,
    input  wire logic [7:0]  pin_oe_in,
    input  wire logic [7:0]  drive_in,
    input  wire logic        fight_in,
    input  wire logic        req_in,
    input  wire logic        we_in,
    input  wire logic [11:0] addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic [2:0]  delay_in,
    output logic      [7:0]  pin_level_out,
    output logic      [7:0]  rdata_out,
    output logic             ack_out,
    output logic      [20:0] seen_out
);
    logic [2:0] cnt_r;

    // Shorted pins follow the far side, so latch and pin can disagree
    assign pin_level_out = fight_in ? drive_in
                         : (pin_oe_in & pin_out_in) | (~pin_oe_in & drive_in);

    initial
    begin
        ack_out = 1'b0;
        rdata_out = 8'h00;
        cnt_r = 3'h0;
    end

    always @(posedge clk_in)
    begin
        if (req_in && !ack_out && cnt_r == delay_in)
        begin
            ack_out <= 1'b1;
            rdata_out <= addr_in[7:0] ^ 8'h5A;
        end
        else
        begin
            ack_out <= 1'b0;
            // Idle bus data keeps moving so stale values are not mistaken for answers
            rdata_out <= ~rdata_out;
        end
        cnt_r <= (req_in && !ack_out) ? cnt_r + 3'h1 : 3'h0;
        if (req_in && ack_out)
            seen_out <= {we_in, addr_in, wdata_in};
    end
endmodule
`default_nettype wire

/* File: pedc_pin_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module pedc_pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             ce_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] stable_out
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;

    if (WIDTH < 1)
    begin : g_chk
        $error("pedc_pin_sync: WIDTH must be positive");
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            s1_r       <= '0;
            s2_r       <= '0;
            s3_r       <= '0;
            stable_out <= '0;
        end
        else if (ce_in)
        begin
            s1_r       <= async_in;
            s2_r       <= s1_r;
            s3_r       <= s2_r;
            // A bit moves only once the last two stages agree
            stable_out <= (s2_r & s3_r) | (stable_out & (s2_r ^ s3_r));
        end
    end
endmodule
`default_nettype wire

/* File: pedc_pkg.sv */
package pedc_pkg;

    typedef enum logic [1:0] {
        PEDC_MODE_SINGLE     = 2'b00,
        PEDC_MODE_EXPANDED   = 2'b01,
        PEDC_MODE_EMUL_EXP   = 2'b10,
        PEDC_MODE_SPER       = 2'b11
    } pedc_mode_e;

    typedef enum logic [1:0] {
        PEDC_ST_IDLE = 2'b00,
        PEDC_ST_EXT  = 2'b01,
        PEDC_ST_RESP = 2'b10
    } pedc_state_e;

endpackage

/* File: pedc_port_read.sv */
`timescale 1ns/10ps
`default_nettype none
module pedc_port_read #(
    parameter int WIDTH = 8
) (
    input  wire logic [WIDTH-1:0] dir_in,
    input  wire logic [WIDTH-1:0] latch_in,
    input  wire logic [WIDTH-1:0] pins_in,
    output logic      [WIDTH-1:0] value_out
);
    if (WIDTH < 1)
    begin : g_chk
        $error("pedc_port_read: WIDTH must be positive");
    end

    always_comb
    begin
        value_out = (dir_in & latch_in) | (~dir_in & pins_in);
    end
endmodule
`default_nettype wire

/* File: pedc_regs.svh */
// Function
// - Direction bit one drives pin as output
// - Direction field sits in bits seven to two
// - Pins one and zero never become outputs
// - Pins one and zero always readable
// - Input pin reads buffered pin state
// - Output pin reads stored latch value
// - Absent in expanded/special peripheral, forwarded externally
// - Absent in expanded modes when emulation set
// - Read and write anytime while mapped
// - Offset nine from relocatable module base
`ifndef PEDC_REGS_SVH
`define PEDC_REGS_SVH

`define PEDC_ADDR_W       12
`define PEDC_PORT_W       8
`define PEDC_IDX_DATA     8'h08
`define PEDC_IDX_DIR      8'h09
`define PEDC_IDX_CFG      8'h0A
`define PEDC_IDX_PINS     8'h0B
`define PEDC_DIR_MASK     8'hFC
`define PEDC_CFG_MODE_LSB 0
`define PEDC_CFG_EME_BIT  2
`define PEDC_CFG_BASE_LSB 4
`define PEDC_RST_DIR      8'h00
`define PEDC_RST_DATA     8'h00
`define PEDC_RST_BASE     4'h0
`define PEDC_BUS_CYCLE_NS 50
`define PEDC_CLK_MHZ      20
`define PEDC_READ_GAP_CYC ((`PEDC_BUS_CYCLE_NS * `PEDC_CLK_MHZ + 999) / 1000)

`endif

/* File: pedc_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pedc_regs.svh"
module pedc_top (
    input  wire logic                    sys_clk_in,
    input  wire logic                    resetn_in,
    input  wire logic                    ce_in,
    input  wire logic [`PEDC_ADDR_W-1:0] avs_address_in,
    input  wire logic                    avs_read_in,
    input  wire logic                    avs_write_in,
    input  wire logic [31:0]             avs_writedata_in,
    input  wire logic [3:0]              avs_byteenable_in,
    output logic      [31:0]             avs_readdata_out,
    output logic                         avs_waitrequest_out,
    input  wire logic [`PEDC_PORT_W-1:0] port_pin_in,
    output logic      [`PEDC_PORT_W-1:0] port_pin_out,
    output logic      [`PEDC_PORT_W-1:0] port_pin_oe_out,
    output logic                         ext_req_out,
    output logic                         ext_we_out,
    output logic      [`PEDC_ADDR_W-1:0] ext_addr_out,
    output logic      [7:0]              ext_wdata_out,
    input  wire logic [7:0]              ext_rdata_in,
    input  wire logic                    ext_ack_in
);
    logic                    rst_s1_r;
    logic                    rst_n_r;
    logic [`PEDC_PORT_W-1:0] dir_r;
    logic [`PEDC_PORT_W-1:0] latch_r;
    pedc_pkg::pedc_mode_e    mode_r;
    logic                    eme_r;
    logic [3:0]              base_r;
    pedc_pkg::pedc_state_e   state_r;
    logic                    fwd_r;
    logic [`PEDC_PORT_W-1:0] pin_sync;
    logic [`PEDC_PORT_W-1:0] port_value;
    logic                    req;
    logic                    hit_dir;
    logic                    hit_data;
    logic                    hit_cfg;
    logic                    hit_pins;
    logic                    dir_absent;
    logic                    local_we;
    logic [7:0]              rdata_nxt;

    // Register byte address inside the relocatable block
    function automatic logic hit(
        input logic [`PEDC_ADDR_W-1:0] addr,
        input logic [3:0]              base,
        input logic [7:0]              idx
    );
        hit = (addr == {base, idx[5:0], 2'b00});
    endfunction

    function automatic logic absent(
        input pedc_pkg::pedc_mode_e mode,
        input logic                 port_e_emulation_enable
    );
        absent = (mode == pedc_pkg::PEDC_MODE_EXPANDED)
              || (mode == pedc_pkg::PEDC_MODE_SPER)
              || ((mode == pedc_pkg::PEDC_MODE_EMUL_EXP) && port_e_emulation_enable);
    endfunction

    // Reset release synchroniser
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end
        else if (ce_in)
        begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    pedc_pin_sync #(
        .WIDTH (`PEDC_PORT_W)
    ) u_pin_sync (
        .clk_in     (sys_clk_in),
        .rst_n_in   (rst_n_r),
        .ce_in      (ce_in),
        .async_in   (port_pin_in),
        .stable_out (pin_sync)
    );

    pedc_port_read #(
        .WIDTH (`PEDC_PORT_W)
    ) u_port_read (
        .dir_in    (dir_r),
        .latch_in  (latch_r),
        .pins_in   (pin_sync),
        .value_out (port_value)
    );

    always_comb
    begin
        req        = avs_read_in || avs_write_in;
        hit_dir    = hit(avs_address_in, base_r, `PEDC_IDX_DIR);
        hit_data   = hit(avs_address_in, base_r, `PEDC_IDX_DATA);
        hit_cfg    = hit(avs_address_in, base_r, `PEDC_IDX_CFG);
        hit_pins   = hit(avs_address_in, base_r, `PEDC_IDX_PINS);
        dir_absent = absent(mode_r, eme_r);
        // Writes land on the edge where the master sees waitrequest low
        local_we   = (state_r == pedc_pkg::PEDC_ST_RESP) && !fwd_r
                  && avs_write_in && avs_byteenable_in[0];
    end

    // Unmapped addresses read as zero and drop writes
    always_comb
    begin
        rdata_nxt = 8'h00;
        if (hit_dir)
        begin
            rdata_nxt = dir_r;
        end
        else if (hit_data)
        begin
            rdata_nxt = port_value;
        end
        else if (hit_cfg)
        begin
            rdata_nxt = {base_r, 1'b0, eme_r, mode_r};
        end
        else if (hit_pins)
        begin
            rdata_nxt = pin_sync;
        end
    end

    // Bus handshake
    always_ff @(posedge sys_clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            state_r             <= pedc_pkg::PEDC_ST_IDLE;
            fwd_r               <= 1'b0;
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out    <= 32'h0000_0000;
        end
        else if (ce_in)
        begin
            case (state_r)
                pedc_pkg::PEDC_ST_IDLE:
                begin
                    if (req && hit_dir && dir_absent)
                    begin
                        state_r <= pedc_pkg::PEDC_ST_EXT;
                        fwd_r   <= 1'b1;
                    end
                    else if (req)
                    begin
                        state_r             <= pedc_pkg::PEDC_ST_RESP;
                        fwd_r               <= 1'b0;
                        avs_waitrequest_out <= 1'b0;
                        avs_readdata_out    <= {24'h00_0000, rdata_nxt};
                    end
                end
                pedc_pkg::PEDC_ST_EXT:
                begin
                    if (ext_ack_in)
                    begin
                        state_r             <= pedc_pkg::PEDC_ST_RESP;
                        avs_waitrequest_out <= 1'b0;
                        avs_readdata_out    <= {24'h00_0000, ext_rdata_in};
                    end
                end
                pedc_pkg::PEDC_ST_RESP:
                begin
                    state_r             <= pedc_pkg::PEDC_ST_IDLE;
                    fwd_r               <= 1'b0;
                    avs_waitrequest_out <= 1'b1;
                end
                default:
                begin
                    state_r             <= pedc_pkg::PEDC_ST_IDLE;
                    avs_waitrequest_out <= 1'b1;
                end
            endcase
        end
    end

    // External echo of accesses the block does not own
    always_ff @(posedge sys_clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            ext_req_out   <= 1'b0;
            ext_we_out    <= 1'b0;
            ext_addr_out  <= '0;
            ext_wdata_out <= 8'h00;
        end
        else if (ce_in)
        begin
            if (state_r == pedc_pkg::PEDC_ST_IDLE && req && hit_dir && dir_absent)
            begin
                ext_req_out   <= 1'b1;
                ext_we_out    <= avs_write_in;
                ext_addr_out  <= avs_address_in;
                ext_wdata_out <= avs_writedata_in[7:0];
            end
            else if (state_r == pedc_pkg::PEDC_ST_EXT && ext_ack_in)
            begin
                ext_req_out <= 1'b0;
            end
        end
    end

    // Direction register; low two pins stay input-only
    always_ff @(posedge sys_clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            dir_r <= `PEDC_RST_DIR;
        end
        else if (ce_in && local_we && hit_dir)
        begin
            dir_r <= avs_writedata_in[7:0] & `PEDC_DIR_MASK;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            latch_r <= `PEDC_RST_DATA;
        end
        else if (ce_in && local_we && hit_data)
        begin
            latch_r <= avs_writedata_in[7:0];
        end
    end

    // Mode, emulation and relocation; the block stays reachable here
    always_ff @(posedge sys_clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            mode_r <= pedc_pkg::PEDC_MODE_SINGLE;
            eme_r  <= 1'b0;
            base_r <= `PEDC_RST_BASE;
        end
        else if (ce_in && local_we && hit_cfg)
        begin
            mode_r <= pedc_pkg::pedc_mode_e'(avs_writedata_in[`PEDC_CFG_MODE_LSB +: 2]);
            eme_r  <= avs_writedata_in[`PEDC_CFG_EME_BIT];
            base_r <= avs_writedata_in[`PEDC_CFG_BASE_LSB +: 4];
        end
    end

    always_comb
    begin
        port_pin_out    = latch_r;
        port_pin_oe_out = dir_r;
    end

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_r);

    a_low_pins_input: assert property (port_pin_oe_out[1:0] == 2'b00)
        else $error("Interrupt pins driven as outputs");

    a_dir_low_zero: assert property (
        (state_r == pedc_pkg::PEDC_ST_IDLE) && ce_in && avs_read_in && hit_dir
        && !dir_absent |=> avs_readdata_out[1:0] == 2'b00)
        else $error("Direction bits one and zero not zero");

    a_dir_write_oe: assert property (
        ce_in && local_we && hit_dir
        |=> port_pin_oe_out == ($past(avs_writedata_in[7:0]) & 8'hFC))
        else $error("Pin enables do not follow direction write");

    a_dir_field_pos: assert property (
        ce_in && local_we && hit_dir
        |=> dir_r[7:2] == $past(avs_writedata_in[7:2]))
        else $error("Direction field misplaced");

    a_read_source: assert property (
        (state_r == pedc_pkg::PEDC_ST_IDLE) && ce_in && avs_read_in && hit_data
        |=> avs_readdata_out[7:0] == (($past(dir_r) & $past(latch_r))
            | (~$past(dir_r) & $past(pin_sync))))
        else $error("Port read source wrong");

    a_read_latch: assert property (
        (state_r == pedc_pkg::PEDC_ST_IDLE) && ce_in && avs_read_in && hit_data
        && (dir_r == 8'hFC)
        |=> avs_readdata_out[7:2] == $past(latch_r[7:2]))
        else $error("Output pins not read from latch");

    a_irq_readable: assert property (
        (state_r == pedc_pkg::PEDC_ST_IDLE) && ce_in && avs_read_in && hit_data
        |=> avs_readdata_out[1:0] == $past(pin_sync[1:0]))
        else $error("Interrupt pins not readable");

    a_absent_fwd: assert property (
        (state_r == pedc_pkg::PEDC_ST_IDLE) && ce_in && req && hit_dir
        && (mode_r inside {pedc_pkg::PEDC_MODE_EXPANDED, pedc_pkg::PEDC_MODE_SPER})
        |=> ext_req_out && avs_waitrequest_out)
        else $error("Absent access not forwarded");

    a_emul_fwd: assert property (
        (state_r == pedc_pkg::PEDC_ST_IDLE) && ce_in && req && hit_dir && eme_r
        && (mode_r == pedc_pkg::PEDC_MODE_EMUL_EXP)
        |=> ext_req_out)
        else $error("Emulation access not forwarded");

    a_mapped_answer: assert property (
        (state_r == pedc_pkg::PEDC_ST_IDLE) && ce_in && req && hit_dir && !dir_absent
        |=> !avs_waitrequest_out && !ext_req_out ##1 (avs_waitrequest_out || !ce_in))
        else $error("Mapped direction access not answered");

    a_reset_inputs: assert property ($rose(rst_n_r) |-> dir_r == 8'h00)
        else $error("Direction not cleared by reset");

    c_fwd_access: cover property (ext_req_out && ext_ack_in);
    c_mixed_read: cover property (
        (state_r == pedc_pkg::PEDC_ST_IDLE) && avs_read_in && hit_data
        && (dir_r != 8'h00));
    c_dir_write: cover property (local_we && hit_dir && avs_writedata_in[0]);
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pedc_regs.svh"
module tb;
    logic        clk = 1'b0;
    // Starts high so the first reset is a real falling edge
    logic        rst_n = 1'b1;
    logic [11:0] addr = 12'h000;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [3:0]  be = 4'hF;
    logic [31:0] rdq;
    logic        waitreq;
    logic [7:0]  pins, pout, poe, erd, ewd, v, lat, keep;
    logic [7:0]  drive = 8'h00;
    logic        fight = 1'b0;
    logic        ce = 1'b1;
    logic        ereq, ewe, eack, ab;
    logic [11:0] eaddr, ea;
    logic [2:0]  dly = 3'h0;
    logic [2:0]  m;
    logic [20:0] seen;
    logic [3:0]  base = 4'h0;
    logic [3:0]  b;
    logic [31:0] q;
    int          n_mismatch = 0;
    int          compares = 0;
    int          seed = 83;

    always #25 clk = ~clk;

    pedc_top i_pedc_top (.sys_clk_in(clk), .resetn_in(rst_n), .ce_in(ce),
        .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_byteenable_in(be), .avs_readdata_out(rdq), .avs_waitrequest_out(waitreq),
        .port_pin_in(pins), .port_pin_out(pout), .port_pin_oe_out(poe), .ext_req_out(ereq),
        .ext_we_out(ewe), .ext_addr_out(eaddr), .ext_wdata_out(ewd), .ext_rdata_in(erd),
        .ext_ack_in(eack));

    pedc_far_side i_pedc_far_side (.clk_in(clk), .pin_out_in(pout), .pin_oe_in(poe),
        .drive_in(drive), .fight_in(fight), .req_in(ereq), .we_in(ewe), .addr_in(eaddr),
        .wdata_in(ewd), .delay_in(dly), .pin_level_out(pins), .rdata_out(erd),
        .ack_out(eack), .seen_out(seen));

    function automatic logic [11:0] ra(input logic [7:0] idx);
        return {base, 8'h00} + {2'b00, idx, 2'b00};
    endfunction

    function automatic logic [7:0] exp_rd(input logic [7:0] d, input logic [7:0] l,
                                          input logic [7:0] p);
        return (d & l) | (~d & p);
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Starts just after a rising edge; holds until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       output logic [31:0] r);
        addr <= ra(idx);
        wd <= {24'($random(seed)), d};
        rd <= !w;
        wr <= w;
        @(posedge clk);
        // No cycle budget here: only the watchdog ends a hung wait
        while (waitreq !== 1'b0)
        begin
            @(posedge clk);
        end
        r = rdq;
        chk("rd_hi", 32'h0, {8'h00, r[31:8]});
        rd <= 1'b0;
        wr <= 1'b0;
        be <= 4'hF;
        @(posedge clk);
    endtask

    task tally_and_finish;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        base = 4'h0;
        bus(0, `PEDC_IDX_DIR, 8'h00, q);
        chk("dir_rst", 32'h0, q);
        chk("oe_rst", 32'h0, {24'h0, poe});
    endtask

    initial
    begin
        #250000;
        n_mismatch++;
        tally_and_finish();
    end

    initial
    begin
        do_reset();
        for (int k = 0; k < 20; k++)
        begin
            lat = 8'($random(seed));
            // Pins seven to two outputs, then all inputs, before the random mix
            v = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($random(seed));
            bus(1, `PEDC_IDX_DATA, lat, q);
            bus(1, `PEDC_IDX_DIR, v, q);
            drive <= 8'($random(seed));
            fight <= 1'($random(seed));
            // Frozen edges between transfers must not disturb anything
            ce <= 1'b0;
            repeat (2) @(posedge clk);
            ce <= 1'b1;
            repeat (6) @(posedge clk);
            bus(0, `PEDC_IDX_DIR, 8'h00, q);
            chk("dir", {24'h0, v & `PEDC_DIR_MASK}, q);
            chk("oe", {24'h0, v & `PEDC_DIR_MASK}, {24'h0, poe});
            chk("pout", {24'h0, lat}, {24'h0, pout});
            bus(0, `PEDC_IDX_DATA, 8'h00, q);
            chk("data", {24'h0, exp_rd(v & `PEDC_DIR_MASK, lat, drive)}, q);
            bus(0, `PEDC_IDX_PINS, 8'h00, q);
            chk("pins", {24'h0, fight ? drive : exp_rd(v & `PEDC_DIR_MASK, lat, drive)}, q);
        end
        // Low lane disabled: the write must be dropped
        be <= 4'hE;
        bus(1, `PEDC_IDX_DIR, ~v, q);
        bus(0, `PEDC_IDX_DIR, 8'h00, q);
        chk("be_drop", {24'h0, v & `PEDC_DIR_MASK}, q);
        bus(0, 8'h20, 8'h00, q);
        chk("unmapped", 32'h0, q);
        keep = v & `PEDC_DIR_MASK;
        for (int i = 0; i < 8; i++)
        begin
            m = 3'(i);
            ab = m[0] || (m == 3'b110);
            ea = ra(`PEDC_IDX_DIR);
            dly <= 3'($random(seed));
            bus(1, `PEDC_IDX_CFG, {base, 1'b0, m}, q);
            v = 8'($random(seed));
            bus(1, `PEDC_IDX_DIR, v, q);
            if (ab)
                chk("ext_w", {11'h0, 1'b1, ea, v}, {11'h0, seen});
            else
                keep = v & `PEDC_DIR_MASK;
            chk("oe_mode", {24'h0, keep}, {24'h0, poe});
            bus(0, `PEDC_IDX_DIR, 8'h00, q);
            chk("dir_mode", {24'h0, ab ? ea[7:0] ^ 8'h5A : keep}, q);
            if (ab)
                chk("ext_r", {19'h0, 1'b0, ea}, {19'h0, seen[20:8]});
        end
        b = 4'($random(seed)) | 4'h1;
        bus(1, `PEDC_IDX_CFG, {b, 4'h0}, q);
        base = b;
        bus(0, `PEDC_IDX_CFG, 8'h00, q);
        chk("cfg_moved", {24'h0, b, 4'h0}, q);
        v = 8'($random(seed));
        bus(1, `PEDC_IDX_DIR, v, q);
        bus(0, `PEDC_IDX_DIR, 8'h00, q);
        chk("dir_moved", {24'h0, v & `PEDC_DIR_MASK}, q);
        base = 4'h0;
        bus(0, `PEDC_IDX_DIR, 8'h00, q);
        chk("dir_old", 32'h0, q);
        do_reset();
        tally_and_finish();
    end
endmodule
`default_nettype wire
